// >>> rtl/enable_fault_relay_logic.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "relay_consts.svh"


module enable_fault_relay_logic #(
	parameter int unsigned         BRAKE_DELAY_CYCLES = `BRAKE_DELAY_MS * `PCLK_KHZ,
	parameter logic [`FAULT_W-1:0] RESETTABLE_MASK    = `RESETTABLE_DEFAULT
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [`ADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	input  wire logic               enable_in,
	input  wire logic               main_power_in,
	input  wire logic               motor_overtemp_input,
	input  wire logic [`FAULT_W-2:0] fault_in,
	output var  logic               relay_out,
	output var  logic               irq
);

	localparam int CNT_W = $clog2(BRAKE_DELAY_CYCLES + 1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	relay_pkg::relay_cfg_s   cfg;
	relay_pkg::relay_cfg_s   next_cfg;
	relay_pkg::brake_tmr_e   tmr_state;
	relay_pkg::brake_tmr_e   next_tmr_state;
	relay_pkg::drive_state_s drive_state;
	logic [CNT_W-1:0]        tmr_count;
	logic [CNT_W-1:0]        next_tmr_count;
	logic [`FAULT_W-1:0]     fault;
	logic [`FAULT_W-1:0]     next_fault;
	logic [`FAULT_W-1:0]     fault_live;
	logic [`FAULT_W-1:0]     fault_clear;
	logic [`EV_W-1:0]        int_stat;
	logic [`EV_W-1:0]        next_int_stat;
	logic [`EV_W-1:0]        int_mask;
	logic [`EV_W-1:0]        next_int_mask;
	logic [`EV_W-1:0]        events;
	logic [`EV_W-1:0]        w1c_bits;
	logic                    en_level;
	logic                    en_rise;
	logic                    drive_enabled;
	logic                    next_enabled;
	logic                    ot_fault;
	logic                    fault_now;
	logic                    tmr_abort;
	logic                    next_relay;
	logic                    access;
	logic                    done_xfer;
	logic                    sel_ctrl;
	logic                    sel_fault;
	logic                    sel_state;
	logic                    sel_int_stat;
	logic                    sel_int_mask;
	logic                    addr_hit;
	logic                    wr_ctrl;
	logic                    wr_int_stat;
	logic                    wr_int_mask;
	logic [31:0]             rd_data;

	// ----------------------------------------------------------------
	// enable input conditioning
	// ----------------------------------------------------------------
	// synchroniser and edge pulse
	enable_sync u_enable_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in (enable_in),
		.level    (en_level),
		.rise     (en_rise)
	);

	// drive becomes enabled only on an edge, drops with the level
	assign next_enabled = en_rise | (drive_enabled & en_level);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_enabled <= 1'b0;
		end else begin
			drive_enabled <= next_enabled;
		end
	end

	// ----------------------------------------------------------------
	// fault latching
	// ----------------------------------------------------------------
	// open thermal contact is an over-temperature, only when checked
	assign ot_fault    = cfg.check_overtemp_setting & ~motor_overtemp_input;
	assign fault_live  = {fault_in, ot_fault};
	assign fault_clear = en_rise ? RESETTABLE_MASK : '0;
	// a fault present in the clearing cycle stays set
	assign next_fault  = (fault & ~fault_clear) | fault_live;
	assign fault_now   = |next_fault;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault <= '0;
		end else begin
			fault <= next_fault;
		end
	end

	// ----------------------------------------------------------------
	// brake delay timer
	// ----------------------------------------------------------------
	// disable or fault stops the delay and forgets it
	assign tmr_abort = ~en_level | fault_now;

	always_comb begin
		next_tmr_state = tmr_state;
		next_tmr_count = tmr_count;
		unique case (tmr_state)
			relay_pkg::TMR_IDLE: begin
				if (en_rise) begin
					next_tmr_state = relay_pkg::TMR_RUN;
					next_tmr_count = CNT_W'(BRAKE_DELAY_CYCLES - 1);
				end
			end
			relay_pkg::TMR_RUN: begin
				if (tmr_abort) begin
					next_tmr_state = relay_pkg::TMR_IDLE;
				end else if (tmr_count == '0) begin
					next_tmr_state = relay_pkg::TMR_DONE;
				end else begin
					next_tmr_count = tmr_count - 1'b1;
				end
			end
			relay_pkg::TMR_DONE: begin
				if (tmr_abort) begin
					next_tmr_state = relay_pkg::TMR_IDLE;
				end
			end
			default: begin
				next_tmr_state = relay_pkg::TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_state <= relay_pkg::TMR_IDLE;
			tmr_count <= '0;
		end else begin
			tmr_state <= next_tmr_state;
			tmr_count <= next_tmr_count;
		end
	end

	// ----------------------------------------------------------------
	// relay output
	// ----------------------------------------------------------------
	// healthy mode: fault-free; brake mode: power, enable, delay, fault-free
	assign next_relay = ~fault_now & (~cfg.brake_mode |
		(main_power_in & drive_enabled & en_level &
		(tmr_state == relay_pkg::TMR_DONE)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_out <= 1'b0;
		end else begin
			relay_out <= next_relay;
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	assign events[`EV_ENABLE_BIT]    = en_rise;
	assign events[`EV_FAULT_BIT]     = |(fault_live & ~fault);
	assign events[`EV_RELAY_ON_BIT]  = next_relay & ~relay_out;
	assign events[`EV_RELAY_OFF_BIT] = ~next_relay & relay_out;
	assign w1c_bits      = wr_int_stat ? pwdata[`EV_W-1:0] : '0;
	// set wins over a write-one-to-clear in the same cycle
	assign next_int_stat = (int_stat & ~w1c_bits) | events;
	assign next_int_mask = wr_int_mask ? pwdata[`EV_W-1:0] : int_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat <= `INT_RESET;
			int_mask <= `INT_RESET;
			irq      <= 1'b0;
		end else begin
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			irq      <= |(next_int_stat & next_int_mask);
		end
	end

	// ----------------------------------------------------------------
	// apb slave, one wait state per transfer
	// ----------------------------------------------------------------
	assign access       = psel & penable;
	assign done_xfer    = access & pready;
	assign sel_ctrl     = (paddr == `REG_CTRL);
	assign sel_fault    = (paddr == `REG_FAULT);
	assign sel_state    = (paddr == `REG_STATE);
	assign sel_int_stat = (paddr == `REG_INT_STAT);
	assign sel_int_mask = (paddr == `REG_INT_MASK);
	assign addr_hit     = sel_ctrl | sel_fault | sel_state | sel_int_stat | sel_int_mask;
	assign wr_ctrl      = done_xfer & pwrite & sel_ctrl;
	assign wr_int_stat  = done_xfer & pwrite & sel_int_stat;
	assign wr_int_mask  = done_xfer & pwrite & sel_int_mask;
	// only configuration and the interrupt status and mask are writable, the relay has no write path
	assign next_cfg     = wr_ctrl ? relay_pkg::relay_cfg_s'(pwdata[`CTRL_W-1:0]) : cfg;

	// read data selection
	assign drive_state.timer_done = (tmr_state == relay_pkg::TMR_DONE);
	assign drive_state.main_power = main_power_in;
	assign drive_state.enabled    = drive_enabled;
	assign drive_state.relay      = relay_out;
	assign rd_data = ({32{sel_ctrl}}     & 32'(cfg)) |
	                 ({32{sel_fault}}    & 32'(fault)) |
	                 ({32{sel_state}}    & 32'(drive_state)) |
	                 ({32{sel_int_stat}} & 32'(int_stat)) |
	                 ({32{sel_int_mask}} & 32'(int_mask));

	// configuration register, healthy mode out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= relay_pkg::relay_cfg_s'(`CTRL_RESET);
		end else begin
			cfg <= next_cfg;
		end
	end

	// answer in the second access cycle, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~addr_hit;
			prdata  <= (access & ~pready & ~pwrite) ? rd_data : '0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [31:0]         run_cycles;
	logic [`FAULT_W-1:0] kept_faults;
	logic                brake_ok;

	assign kept_faults = fault & ~RESETTABLE_MASK;
	assign brake_ok    = main_power_in & drive_enabled & en_level & ~fault_now;

	// cycles spent in the delay state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cycles <= '0;
		end else if (tmr_state == relay_pkg::TMR_RUN) begin
			run_cycles <= run_cycles + 32'h0000_0001;
		end else begin
			run_cycles <= '0;
		end
	end

	sequence s_enable_edge;
		en_rise && cfg.brake_mode;
	endsequence

	sequence s_relay_held_off;
		!relay_out [*8];
	endsequence

	property p_steady_level_idle;
		(tmr_state == relay_pkg::TMR_IDLE && !en_rise) |=> tmr_state == relay_pkg::TMR_IDLE;
	endproperty
	a_steady_level_idle: assert property (p_steady_level_idle)
		else $error("timer started without an enable edge");

	property p_clear_resettable;
		en_rise |=> ((fault & RESETTABLE_MASK & ~$past(fault_live)) == '0) &&
			(kept_faults == ($past(kept_faults) | (~RESETTABLE_MASK & $past(fault_live))));
	endproperty
	a_clear_resettable: assert property (p_clear_resettable)
		else $error("enable edge did not clear faults correctly");

	property p_mode_only_by_write;
		!wr_ctrl |=> $stable(cfg.brake_mode);
	endproperty
	a_mode_only_by_write: assert property (p_mode_only_by_write)
		else $error("relay mode changed without a write");

	property p_healthy_relay;
		(!cfg.brake_mode && !fault_now) |=> relay_out;
	endproperty
	a_healthy_relay: assert property (p_healthy_relay)
		else $error("healthy relay off with no fault");

	property p_brake_conditions;
		(relay_out && $past(cfg.brake_mode)) |-> $past(brake_ok);
	endproperty
	a_brake_conditions: assert property (p_brake_conditions)
		else $error("brake relay on without power, enable or fault-free");

	property p_brake_delay_start;
		s_enable_edge |=> s_relay_held_off;
	endproperty
	a_brake_delay_start: assert property (p_brake_delay_start)
		else $error("brake relay on too soon after enable edge");

	property p_brake_delay_length;
		(tmr_state == relay_pkg::TMR_RUN && tmr_count == '0) |->
			run_cycles == 32'(BRAKE_DELAY_CYCLES - 1);
	endproperty
	a_brake_delay_length: assert property (p_brake_delay_length)
		else $error("brake delay length wrong");

	property p_brake_drop;
		(cfg.brake_mode && (fault_now || !en_level)) |=> !relay_out;
	endproperty
	a_brake_drop: assert property (p_brake_drop)
		else $error("brake relay not dropped at once");

	property p_fault_forces_off;
		fault_now |=> !relay_out [*1] ##0 !$rose(relay_out);
	endproperty
	a_fault_forces_off: assert property (p_fault_forces_off)
		else $error("relay on while a fault is present");

	property p_overtemp_ignored;
		(!cfg.check_overtemp_setting && !fault[`FAULT_OT_BIT] && !en_rise) |=>
			!fault[`FAULT_OT_BIT];
	endproperty
	a_overtemp_ignored: assert property (p_overtemp_ignored)
		else $error("over-temperature fault while check is off");

	property p_open_contact_faults;
		(cfg.check_overtemp_setting && !motor_overtemp_input) |=> fault[`FAULT_OT_BIT] ##1 1'b1;
	endproperty
	a_open_contact_faults: assert property (p_open_contact_faults)
		else $error("open thermal contact did not raise a fault");

	property p_closed_contact_ok;
		(cfg.check_overtemp_setting && motor_overtemp_input && !fault[`FAULT_OT_BIT]) |=>
			!fault[`FAULT_OT_BIT];
	endproperty
	a_closed_contact_ok: assert property (p_closed_contact_ok)
		else $error("closed thermal contact raised a fault");

	property p_edge_pulse;
		en_rise |=> !en_rise && tmr_state == relay_pkg::TMR_RUN;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse)
		else $error("enable edge pulse wrong or timer not started");

endmodule : enable_fault_relay_logic

`default_nettype wire

// >>> rtl/enable_sync.sv
`timescale 1ns/1ps
`default_nettype none

module enable_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output var  logic level,
	output var  logic rise
);

	logic meta;
	logic sync;
	logic hist;

	// two-flop synchroniser, then one history flop for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			hist <= 1'b0;
		end else begin
			meta <= async_in;
			sync <= meta;
			hist <= sync;
		end
	end

	// single-cycle pulse on a low-to-high change
	assign level = sync;
	assign rise  = sync & ~hist;

endmodule : enable_sync

`default_nettype wire

// >>> rtl/relay_consts.svh
`ifndef RELAY_CONSTS_SVH
`define RELAY_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte addresses on the apb bus)
// ----------------------------------------------------------------
`define ADDR_W          12
`define REG_CTRL        12'h000
`define REG_FAULT       12'h004
`define REG_STATE       12'h008
`define REG_INT_STAT    12'h00c
`define REG_INT_MASK    12'h010

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_BRAKE_BIT  0
`define CTRL_COT_BIT    1
`define CTRL_W          2
`define CTRL_RESET      2'h2
`define FAULT_W         8
`define FAULT_OT_BIT    0
`define RESETTABLE_DEFAULT 8'h7f
`define EV_W            4
`define EV_ENABLE_BIT   0
`define EV_FAULT_BIT    1
`define EV_RELAY_ON_BIT 2
`define EV_RELAY_OFF_BIT 3
`define INT_RESET       4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BRAKE_DELAY_MS  200
`define PCLK_KHZ        200000

`endif

// >>> rtl/relay_pkg.sv
`include "relay_consts.svh"

package relay_pkg;

	// brake delay timer states
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_RUN  = 2'b01,
		TMR_DONE = 2'b10
	} brake_tmr_e;

	// software configuration, low bit is the relay mode
	typedef struct packed {
		logic check_overtemp_setting;
		logic brake_mode;
	} relay_cfg_s;

	// drive state as seen by software
	typedef struct packed {
		logic timer_done;
		logic main_power;
		logic enabled;
		logic relay;
	} drive_state_s;

endpackage : relay_pkg

// >>> sim/drive_field.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// field side: enable source, contact, brake coil
// ------------------------------------------------
module drive_field (
	input  wire logic       pclk,
	input  wire logic       en_req,
	input  wire logic       power_req,
	input  wire logic       motor_hot,
	input  wire logic       tach_mode,
	input  wire logic [6:0] fault_req,
	input  wire logic       relay_out,
	output var  logic       enable_in,
	output var  logic       main_power_in,
	output var  logic       motor_overtemp_input,
	output var  logic [6:0] fault_in,
	output var  logic       brake_free
);
	// pins follow the requests one edge later, the contact inverted from motor_hot, or toggling every edge in tach mode
	always @(posedge pclk) begin
		enable_in <= en_req;
		main_power_in <= power_req;
		fault_in <= fault_req;
		brake_free <= relay_out; // energised coil lifts the brake
		if (tach_mode) begin
			motor_overtemp_input <= ~motor_overtemp_input;
		end else begin
			motor_overtemp_input <= ~motor_hot;
		end
	end
endmodule : drive_field

`default_nettype wire

// >>> sim/enable_fault_relay_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "relay_consts.svh"

module enable_fault_relay_logic_bench;
	localparam int BRK = 20;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, relay_out, irq, brake_free;
	logic        enable_in, main_power_in, motor_overtemp_input;
	logic [6:0]  fault_in, fault_req;
	logic        en_req, power_req, motor_hot, tach_mode;
	int          failures, cmp_count;
	// row: ctrl, hot, tach, faults, expected fault reg, expected relay
	localparam logic [19:0] ROWS [6] = '{
		{2'h2, 1'b1, 1'b0, 7'h00, 8'h01, 1'b0},
		{2'h0, 1'b1, 1'b0, 7'h00, 8'h00, 1'b1},
		{2'h2, 1'b0, 1'b0, 7'h00, 8'h00, 1'b1},
		{2'h0, 1'b0, 1'b1, 7'h00, 8'h00, 1'b1},
		{2'h2, 1'b0, 1'b0, 7'h01, 8'h02, 1'b0},
		{2'h2, 1'b0, 1'b0, 7'h20, 8'h40, 1'b0}};

	always #2.5 pclk = ~pclk;

	enable_fault_relay_logic #(.BRAKE_DELAY_CYCLES(BRK)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_in(enable_in),
		.main_power_in(main_power_in), .motor_overtemp_input(motor_overtemp_input),
		.fault_in(fault_in), .relay_out(relay_out), .irq(irq));

	drive_field field (.pclk(pclk), .en_req(en_req), .power_req(power_req),
		.motor_hot(motor_hot), .tach_mode(tach_mode), .fault_req(fault_req),
		.relay_out(relay_out), .enable_in(enable_in), .main_power_in(main_power_in),
		.motor_overtemp_input(motor_overtemp_input), .fault_in(fault_in),
		.brake_free(brake_free));

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks=%0d failures=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) failures++;
		// one idle edge so the next request never reassigns psel in this step
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// enable edge, then time the relay turn-on in brake mode
	task automatic brake_on;
		int n;
		n = 0;
		en_req <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (relay_out !== 1'b1 && n < 200);
		chk(32'(n >= BRK + 2), 32'h1);
		chk(32'(n <= BRK + 10), 32'h1);
	endtask : brake_on

	task automatic pulse_en;
		en_req <= 1'b1;
		cyc(6);
		en_req <= 1'b0;
		cyc(5);
	endtask : pulse_en

	initial begin
		#100us;
		failures++;
		end_sim();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		logic [31:0] r;
		logic        e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		en_req = 1'b0;
		power_req = 1'b1;
		motor_hot = 1'b0;
		tach_mode = 1'b0;
		fault_req = 7'h00;
		failures = 0;
		cmp_count = 0;
		cyc(6);
		presetn <= 1'b1;
		cyc(4);
		rd(`REG_CTRL, 32'h2);
		rd(`REG_FAULT, 32'h0);
		rd(`REG_INT_MASK, 32'h0);
		wr(`REG_STATE, 32'h0);
		wr(`REG_FAULT, 32'hff);
		cyc(2);
		chk({31'h0, relay_out}, 32'h1);
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		// interrupt raised, masked and cleared
		wr(`REG_INT_STAT, 32'hf);
		wr(`REG_INT_MASK, 32'h2);
		chk({31'h0, irq}, 32'h0);
		fault_req <= 7'h01;
		cyc(4);
		fault_req <= 7'h00;
		chk({31'h0, irq}, 32'h1);
		wr(`REG_INT_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`REG_INT_MASK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(`REG_INT_STAT, 32'h2);
		chk({31'h0, irq}, 32'h0);
		pulse_en();
		// fault table
		foreach (ROWS[i]) begin
			wr(`REG_CTRL, {30'h0, ROWS[i][19:18]});
			motor_hot <= ROWS[i][17];
			tach_mode <= ROWS[i][16];
			fault_req <= ROWS[i][15:9];
			cyc(5);
			rd(`REG_FAULT, {24'h0, ROWS[i][8:1]});
			chk({31'h0, relay_out}, {31'h0, ROWS[i][0]});
			motor_hot <= 1'b0;
			tach_mode <= 1'b0;
			fault_req <= 7'h00;
			cyc(5);
			rd(`REG_FAULT, {24'h0, ROWS[i][8:1]});
			pulse_en();
			rd(`REG_FAULT, 32'h0);
			chk({31'h0, relay_out}, 32'h1);
		end
		// steady enable level clears nothing, bit 7 survives the edge
		en_req <= 1'b1;
		cyc(6);
		fault_req <= 7'h01;
		cyc(3);
		fault_req <= 7'h00;
		cyc(5);
		rd(`REG_FAULT, 32'h2);
		en_req <= 1'b0;
		fault_req <= 7'h40;
		cyc(3);
		fault_req <= 7'h00;
		cyc(3);
		pulse_en();
		rd(`REG_FAULT, 32'h80);
		chk({31'h0, relay_out}, 32'h0);
		presetn <= 1'b0;
		cyc(6);
		presetn <= 1'b1;
		cyc(4);
		rd(`REG_FAULT, 32'h0);
		chk({31'h0, relay_out}, 32'h1);
		// brake mode
		wr(`REG_CTRL, 32'h1);
		cyc(3);
		chk({31'h0, relay_out}, 32'h0);
		brake_on();
		// energised coil lifts the brake one edge later
		cyc(1);
		chk({31'h0, brake_free}, 32'h1);
		// relay, enabled, power and timer done all set
		rd(`REG_STATE, 32'hf);
		power_req <= 1'b0;
		cyc(3);
		chk({31'h0, relay_out}, 32'h0);
		power_req <= 1'b1;
		cyc(3);
		chk({31'h0, relay_out}, 32'h1);
		fault_req <= 7'h01;
		cyc(3);
		chk({31'h0, relay_out}, 32'h0);
		fault_req <= 7'h00;
		en_req <= 1'b0;
		cyc(6);
		brake_on();
		// pin, two sync flops, then the relay flop
		en_req <= 1'b0;
		cyc(5);
		chk({31'h0, relay_out}, 32'h0);
		end_sim();
	end
endmodule : enable_fault_relay_logic_bench

`default_nettype wire
